// *** sts_defines.vh ***
`ifndef STS_DEFINES_VH
`define STS_DEFINES_VH
// Trigger source selection (trig_src).
`define STS_TS_FREE   2'h0
`define STS_TS_EXT    2'h1
`define STS_TS_MAN    2'h2
`define STS_TS_MULTI  2'h3
// Per-sequence sources in multiple-trigger mode.
`define STS_MS_FREE   3'h0
`define STS_MS_EXT1   3'h1
`define STS_MS_EXT2   3'h2
`define STS_MS_AND    3'h3
`define STS_MS_OR     3'h4
`define STS_MS_MAN    3'h5
// Sequence setting.
`define STS_SQ_SWEEP  2'h0
`define STS_SQ_POINT  2'h1
`define STS_SQ_PART   2'h2
`define STS_SQ_SEG    2'h3
// Signal type; bit 1 set means level qualified.
`define STS_SL_RISE   2'h0
`define STS_SL_FALL   2'h1
`define STS_SL_HIGH   2'h2
`define STS_SL_LOW    2'h3
`define STS_SL_LVL    1
// Sweep stages.
`define STS_STG_IDLE  2'h0
`define STS_STG_PREP  2'h1
`define STS_STG_SWEEP 2'h2
`define STS_STG_CALC  2'h3
// Sizes and reset values.
`define STS_NCH       4
`define STS_CW        2
`define STS_CNT_RST   8'h01
`define STS_CH_LAST   2'h3
`endif

// *** sts_sequencer.v ***
`timescale 1ns/100ps
`default_nettype none
`include "sts_defines.vh"
module sts_sequencer (
	// Clock and reset.
	input  wire        ref_clk,
	input  wire        rst_n,
	// Trigger configuration.
	input  wire [1:0]  trig_src,
	input  wire [1:0]  seq_mode,
	input  wire [1:0]  sig_type,
	input  wire [15:0] delay_cyc,
	input  wire        manual_trig,
	// Multiple-trigger table: sweep start and point entries.
	input  wire [2:0]  msrc_sweep,
	input  wire [2:0]  msrc_point,
	input  wire [1:0]  mslope1,
	input  wire [1:0]  mslope2,
	input  wire [15:0] mdelay_sweep,
	input  wire [15:0] mdelay_point,
	// External trigger pins.
	input  wire        ext1_in,
	input  wire        ext2_in,
	// Sweep geometry.
	input  wire [7:0]  num_points,
	input  wire [3:0]  num_parts,
	input  wire        segmented,
	input  wire [7:0]  seg_points,
	// Channel control.
	input  wire [1:0]  chan_sel,
	input  wire        set_single,
	input  wire        set_cont,
	input  wire        count_wr,
	input  wire [7:0]  count_val,
	input  wire        all_cont,
	input  wire        all_hold,
	input  wire [1:0]  active_ch,
	input  wire        scope_all,
	input  wire        restart,
	// Measurement engine handshake.
	output reg         meas_start,
	output reg         meas_abort,
	input  wire        meas_done,
	// Status.
	output reg         trig_skipped,
	output reg  [1:0]  stage,
	output reg  [1:0]  cur_ch,
	output wire        show_index,
	output wire [7:0]  sweep_index,
	output wire [7:0]  sweep_total,
	output wire [3:0]  single_mask
);
	localparam [2:0] ST_IDLE = 3'h0, ST_PREP = 3'h1, ST_WAIT = 3'h2, ST_DLY = 3'h3;
	localparam [2:0] ST_MEAS = 3'h4, ST_BUSY = 3'h5, ST_CALC = 3'h6;

	reg         rs1_reg, rs2_reg;
	wire        srst_n = rs2_reg;
	reg  [2:0]  state_reg;
	reg         at_start_reg, seen1_reg, seen2_reg;
	reg  [15:0] dly_reg;
	reg  [3:0]  part_reg;
	reg  [7:0]  pt_reg, segpt_reg, done_reg;
	reg  [3:0]  pend_reg;
	wire [1:0]  lvl, rise, fall;
	wire [31:0] cnt_flat;
	wire [1:0]  in_pins = {ext2_in, ext1_in};

	// Reset is released through two flops so every flop leaves reset on the same edge.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_reg <= 1'b0;
			rs2_reg <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rs2_reg <= rs1_reg;
		end
	end

	// Pin synchronisers; the filtered level only moves when stages two and three agree.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_pin
			reg s1_reg, s2_reg, s3_reg, st_reg, sd_reg;
			always @(posedge ref_clk or negedge srst_n) begin
				if (!srst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					st_reg <= 1'b0;
					sd_reg <= 1'b0;
				end else begin
					s1_reg <= in_pins[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						st_reg <= s3_reg;
					end
					sd_reg <= st_reg;
				end
			end
			assign lvl[g]  = st_reg;
			assign rise[g] = st_reg & ~sd_reg;
			assign fall[g] = ~st_reg & sd_reg;
		end
		// Per-channel mode bit and sweep count.
		for (g = 0; g < `STS_NCH; g = g + 1) begin : g_ch
			reg       single_reg;
			reg [7:0] count_reg;
			wire      hit = ({30'h0, chan_sel} == g); // Both sides are 32 bits wide, so nothing is cut.
			always @(posedge ref_clk or negedge srst_n) begin
				if (!srst_n) begin
					single_reg <= 1'b0;
					count_reg  <= `STS_CNT_RST;
				end else begin
					if (all_cont) begin
						single_reg <= 1'b0;
					end else if (all_hold) begin
						single_reg <= 1'b1;
					end else if (hit && set_single) begin
						single_reg <= 1'b1;
					end else if (hit && set_cont) begin
						single_reg <= 1'b0;
					end
					if (hit && count_wr && single_reg) begin
						count_reg <= count_val;
					end
				end
			end
			assign single_mask[g] = single_reg;
			assign cnt_flat[g*8 +: 8] = count_reg;
		end
	endgenerate

	// Effective trigger source, slopes and delay for the sequence now awaited.
	reg  [2:0]  src;
	reg  [1:0]  sl1, sl2;
	reg  [15:0] dly_sel;
	always @* begin
		sl1 = sig_type;
		sl2 = sig_type;
		dly_sel = delay_cyc;
		case (trig_src)
			`STS_TS_FREE: begin
				src = `STS_MS_FREE;
				dly_sel = 16'h0000;
			end
			`STS_TS_EXT:  src = `STS_MS_EXT1;
			`STS_TS_MAN:  src = `STS_MS_MAN;
			default: begin
				sl1 = mslope1;
				sl2 = mslope2;
				src = at_start_reg ? msrc_sweep : msrc_point;
				dly_sel = at_start_reg ? mdelay_sweep : mdelay_point;
			end
		endcase
	end

	// Qualify each input with its own slope, then combine.
	wire hit1 = sl1[`STS_SL_LVL] ? (lvl[0] ~^ (sl1 == `STS_SL_HIGH)) :
		((sl1 == `STS_SL_RISE) ? rise[0] : fall[0]);
	wire hit2 = sl2[`STS_SL_LVL] ? (lvl[1] ~^ (sl2 == `STS_SL_HIGH)) :
		((sl2 == `STS_SL_RISE) ? rise[1] : fall[1]);
	wire man_ok = manual_trig && (src == `STS_MS_MAN);
	wire lvl_mode = (src == `STS_MS_EXT2) ? sl2[`STS_SL_LVL] :
		((src != `STS_MS_FREE) && (src != `STS_MS_MAN) && sl1[`STS_SL_LVL]);
	reg fire;
	always @* begin
		case (src)
			`STS_MS_FREE: fire = 1'b1;
			`STS_MS_EXT1: fire = hit1;
			`STS_MS_EXT2: fire = hit2;
			`STS_MS_AND:  fire = (seen1_reg | hit1) & (seen2_reg | hit2);
			`STS_MS_OR:   fire = hit1 | hit2;
			`STS_MS_MAN:  fire = man_ok;
			default:      fire = 1'b0;
		endcase
	end
	// Edge events for the skip notice: those used by the current source, plus input-one edges under the manual source.
	wire ev = man_ok | (~lvl_mode & (((src != `STS_MS_EXT2) && (src != `STS_MS_FREE) && hit1) |
		((src >= `STS_MS_EXT2) && (src <= `STS_MS_OR) && hit2)));

	// Progress boundaries after a partial measurement completes.
	wire part_last  = (part_reg + 4'h1 >= num_parts);
	wire pt_last    = (pt_reg + 8'h01 >= num_points);
	wire seg_last   = (segpt_reg + 8'h01 >= seg_points);
	wire sweep_last = part_last & pt_last;
	reg  unit_end;
	always @* begin
		if (lvl_mode) begin
			unit_end = 1'b1;
		end else if (trig_src == `STS_TS_MULTI) begin
			unit_end = part_last;
		end else begin
			case (seq_mode)
				`STS_SQ_POINT: unit_end = part_last;
				`STS_SQ_PART:  unit_end = 1'b1;
				`STS_SQ_SEG:   unit_end = segmented & part_last & seg_last;
				default:       unit_end = 1'b0;
			endcase
		end
	end

	// Channel scheduling.
	wire [7:0] cur_cnt   = cnt_flat[cur_ch*8 +: 8];
	wire       cur_single = single_mask[cur_ch];
	wire       cnt_done  = (done_reg + 8'h01 >= cur_cnt);
	reg  [1:0] pend_ch, cont_ch;
	reg        cont_any;
	integer    i;
	always @* begin
		pend_ch  = 2'h0;
		cont_ch  = cur_ch;
		cont_any = 1'b0;
		for (i = `STS_NCH - 1; i >= 0; i = i - 1) begin
			if (pend_reg[i]) begin
				pend_ch = i[1:0];
			end
		end
		for (i = `STS_NCH; i >= 1; i = i - 1) begin
			if (!single_mask[cur_ch + i[1:0]]) begin
				cont_ch  = cur_ch + i[1:0];
				cont_any = 1'b1;
			end
		end
	end

	// Sequencer.
	always @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			state_reg    <= ST_IDLE;
			at_start_reg <= 1'b1;
			seen1_reg    <= 1'b0;
			seen2_reg    <= 1'b0;
			dly_reg      <= 16'h0000;
			part_reg     <= 4'h0;
			pt_reg       <= 8'h00;
			segpt_reg    <= 8'h00;
			done_reg     <= 8'h00;
			pend_reg     <= 4'h0;
			cur_ch       <= 2'h0;
			meas_start   <= 1'b0;
			meas_abort   <= 1'b0;
			trig_skipped <= 1'b0;
			stage        <= `STS_STG_IDLE;
		end else begin
			meas_start   <= 1'b0;
			meas_abort   <= 1'b0;
			trig_skipped <= 1'b0;
			if (restart) begin
				state_reg  <= ST_IDLE;
				meas_abort <= 1'b1;
				stage      <= `STS_STG_IDLE;
				part_reg   <= 4'h0;
				pt_reg     <= 8'h00;
				segpt_reg  <= 8'h00;
				done_reg   <= 8'h00;
				seen1_reg  <= 1'b0;
				seen2_reg  <= 1'b0;
				cur_ch     <= active_ch - 2'h1; // Continuous scan starts at the active channel.
				if (scope_all) begin
					pend_reg <= single_mask;
				end else if (single_mask[active_ch]) begin
					pend_reg <= 4'h1 << active_ch;
				end else begin
					pend_reg <= 4'h0;
				end
			end else begin
				if (all_hold) begin
					pend_reg <= 4'h0;
				end
				case (state_reg)
					ST_IDLE: begin
						stage        <= `STS_STG_IDLE;
						at_start_reg <= 1'b1;
						if (pend_reg != 4'h0 && !all_hold) begin
							cur_ch    <= pend_ch;
							state_reg <= ST_PREP;
						end else if (cont_any) begin
							cur_ch    <= cont_ch;
							state_reg <= ST_PREP;
						end
					end
					ST_PREP: begin
						stage     <= `STS_STG_PREP;
						state_reg <= ST_WAIT;
					end
					ST_WAIT: begin
						stage <= `STS_STG_SWEEP;
						seen1_reg <= seen1_reg | hit1;
						seen2_reg <= seen2_reg | hit2;
						if (fire) begin
							seen1_reg <= 1'b0;
							seen2_reg <= 1'b0;
							dly_reg   <= dly_sel;
							state_reg <= ST_DLY;
						end
					end
					ST_DLY: begin
						if (ev) begin
							trig_skipped <= 1'b1;
						end
						if (dly_reg == 16'h0000) begin
							state_reg <= ST_MEAS;
						end else begin
							dly_reg <= dly_reg - 16'h0001;
						end
					end
					ST_MEAS: begin
						at_start_reg <= 1'b0;
						meas_start   <= 1'b1;
						state_reg    <= ST_BUSY;
						if (ev) begin
							trig_skipped <= 1'b1;
						end
					end
					ST_BUSY: begin
						if (ev) begin
							trig_skipped <= 1'b1;
						end
						if (meas_done) begin
							part_reg <= part_last ? 4'h0 : part_reg + 4'h1;
							if (part_last) begin
								pt_reg    <= pt_reg + 8'h01;
								segpt_reg <= seg_last ? 8'h00 : segpt_reg + 8'h01;
							end
							if (sweep_last) begin
								state_reg <= ST_CALC;
							end else if (unit_end) begin
								state_reg <= ST_WAIT;
							end else begin
								state_reg <= ST_MEAS;
							end
						end
					end
					ST_CALC: begin
						stage     <= `STS_STG_CALC;
						pt_reg    <= 8'h00;
						segpt_reg <= 8'h00;
						state_reg <= ST_IDLE;
						if (cur_single) begin
							done_reg <= cnt_done ? 8'h00 : done_reg + 8'h01;
							if (cnt_done) begin
								pend_reg[cur_ch] <= 1'b0;
							end else begin
								pend_reg[cur_ch] <= 1'b1;
							end
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// Progress readout in single mode with more than one sweep.
	assign sweep_total = cur_cnt;
	assign sweep_index = done_reg + 8'h01;
	assign show_index  = cur_single && (cur_cnt > `STS_CNT_RST) && (stage == `STS_STG_SWEEP);
endmodule // sts_sequencer
`default_nettype wire

// *** sts_meas_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sts_meas_model (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Engine handshake.
	input  wire logic       meas_start,
	input  wire logic       meas_abort,
	input  wire logic [3:0] lat,
	output var  logic       meas_done
);
	logic [3:0] cnt;
	// Counts the latency down; an abort drops the job with no done.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt       <= 4'h0;
			meas_done <= 1'b0;
		end else begin
			meas_done <= (cnt == 4'h1) && !meas_abort;
			if (meas_abort)
				cnt <= 4'h0;
			else if (meas_start)
				cnt <= lat;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule // sts_meas_model
`default_nettype wire

// *** sts_seq_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sts_defines.vh"
module sts_seq_asserts (
	// Clock and reset.
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Watched signals.
	input wire logic       restart,
	input wire logic       all_cont,
	input wire logic       all_hold,
	input wire logic       meas_start,
	input wire logic       meas_abort,
	input wire logic       meas_done,
	input wire logic       trig_skipped,
	input wire logic [1:0] stage,
	input wire logic       show_index,
	input wire logic [7:0] sweep_index,
	input wire logic [7:0] sweep_total,
	input wire logic [3:0] single_mask
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic busy;
	// A started job stays open until done or abort closes it.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			busy <= 1'b0;
		else if (meas_start)
			busy <= 1'b1;
		else if (meas_done || meas_abort)
			busy <= 1'b0;
	end
	abort_follows_a: assert property (restart |=> meas_abort) else $error("no abort");
	restart_idle_a: assert property (restart |=> stage == `STS_STG_IDLE && sweep_index == 8'h01) else $error("not idle");
	start_pulse_a: assert property (meas_start |=> !meas_start) else $error("long start");
	skip_pulse_a: assert property (trig_skipped |=> !trig_skipped) else $error("long skip");
	one_job_a: assert property (meas_start |-> !busy) else $error("start while busy");
	index_show_a: assert property (show_index |-> stage == `STS_STG_SWEEP && sweep_total > 8'h01
		&& sweep_index <= sweep_total) else $error("bad index");
	all_cont_a: assert property (all_cont |=> single_mask == 4'h0) else $error("not cont");
	all_hold_a: assert property (all_hold && !all_cont |=> single_mask == 4'hF) else $error("not hold");
	cover property (restart ##1 meas_abort);
	cover property (trig_skipped);
	cover property (show_index);
endmodule // sts_seq_asserts
bind sts_sequencer sts_seq_asserts u_chk (.ref_clk, .rst_n, .restart, .all_cont, .all_hold, .meas_start,
	.meas_abort, .meas_done, .trig_skipped, .stage, .show_index, .sweep_index, .sweep_total, .single_mask);
`default_nettype wire

// *** sts_sequencer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sts_defines.vh"
module sts_sequencer_tb;
	logic ref_clk = 0, rst_n = 0, manual_trig = 0, ext1_in = 0, ext2_in = 0, segmented = 0;
	logic set_single = 0, set_cont = 0, count_wr = 0, all_cont = 0, all_hold = 0, scope_all = 0, restart = 0;
	logic [1:0] trig_src = `STS_TS_MAN, seq_mode = 0, sig_type = 0, mslope1 = 0, mslope2 = 0;
	logic [1:0] chan_sel = 0, active_ch = 0, stage, cur_ch;
	logic [2:0] msrc_sweep = 0, msrc_point = 0;
	logic [15:0] delay_cyc = 0, mdelay_sweep = 0, mdelay_point = 0;
	logic [7:0] num_points = 1, seg_points = 1, count_val = 1, sweep_index, sweep_total;
	logic [3:0] num_parts = 1, single_mask, lat = 1;
	logic meas_start, meas_abort, meas_done, trig_skipped, show_index;
	int miscompares = 0, num_checks = 0, cyc = 0, nst = 0, n0, n1, seed = 32'hceea8de7;
	int qs[$], qk[$];
	bit mon_on = 1;
	sts_sequencer u_dut (.ref_clk, .rst_n, .trig_src, .seq_mode, .sig_type, .delay_cyc, .manual_trig,
		.msrc_sweep, .msrc_point, .mslope1, .mslope2, .mdelay_sweep, .mdelay_point, .ext1_in, .ext2_in,
		.num_points, .num_parts, .segmented, .seg_points, .chan_sel, .set_single, .set_cont, .count_wr,
		.count_val, .all_cont, .all_hold, .active_ch, .scope_all, .restart, .meas_start, .meas_abort,
		.meas_done, .trig_skipped, .stage, .cur_ch, .show_index, .sweep_index, .sweep_total, .single_mask);
	sts_meas_model u_eng (.ref_clk, .rst_n, .meas_start, .meas_abort, .lat, .meas_done);
	// Free-running clock and cycle count.
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	task chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %0h got %0h", n, e, s);
		end
	endtask
	task conclude();
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task tick(int n = 1);
		repeat (n) @(posedge ref_clk);
	endtask
	// Reads the start count off the edge, then returns on a rising edge so that drives stay on it.
	task snap(output int v);
		@(negedge ref_clk);
		v = nst;
		@(posedge ref_clk);
	endtask
	task wait_st(logic [1:0] s);
		for (int i = 0; i < 300 && stage !== s; i++)
			tick();
		chk("stage", stage, s);
	endtask
	// Manual trigger in WAIT; an optional second one lands in the delay.
	task trig(int d, bit dbl);
		int k;
		delay_cyc <= d[15:0];
		wait_st(`STS_STG_SWEEP);
		k = cyc;
		manual_trig <= 1;
		qs.push_back(k + d + 4);
		tick();
		manual_trig <= 0;
		if (dbl) begin
			tick();
			manual_trig <= 1;
			qk.push_back(k + 4);
			tick();
			manual_trig <= 0;
		end
		wait_st(`STS_STG_CALC);
	endtask
	// Each start while mon_on is set, and each skip, is matched with the oldest note; no note means it was not due.
	always @(posedge ref_clk) begin
		if (meas_start === 1'b1) begin
			nst++;
			if (mon_on)
				chk("start_cyc", cyc, qs.size() ? qs.pop_front() : -1);
		end
		if (trig_skipped === 1'b1)
			chk("skip_cyc", cyc, qk.size() ? qk.pop_front() : -1);
	end
	// Watchdog well beyond the roughly 1500 cycles that the tests take.
	initial begin
		tick(20000);
		miscompares++;
		conclude();
	end
	initial begin
		tick(3);
		rst_n <= 1;
		for (int m = 0; m < 4; m++) begin
			seq_mode <= m[1:0];
			lat <= 4'h1 + 4'($unsigned($random(seed)) % 8);
			trig($unsigned($random(seed)) % 12, 0);
		end
		trig(10, 1);
		wait_st(`STS_STG_SWEEP);
		trig_src <= `STS_TS_EXT;
		manual_trig <= 1;
		tick();
		manual_trig <= 0;
		tick(30);
		mon_on <= 0;
		snap(n0);
		ext1_in <= 1;
		tick(100);
		snap(n1);
		chk("edge", n1 - n0, 1);
		trig_src <= `STS_TS_FREE;
		snap(n0);
		tick(200);
		snap(n1);
		chk("free", n1 - n0 >= 8, 1);
		all_hold <= 1;
		tick();
		all_hold <= 0;
		tick(40);
		count_val <= 8'h03;
		count_wr <= 1;
		tick();
		count_wr <= 0;
		restart <= 1;
		tick();
		restart <= 0;
		snap(n0);
		wait_st(`STS_STG_SWEEP);
		chk("cur_ch", cur_ch, 0);
		chk("total", sweep_total, 3);
		chk("index", sweep_index, 1);
		chk("show", show_index, 1);
		tick(300);
		snap(n1);
		chk("single", n1 - n0, 3);
		chk("mask", single_mask, 4'hF);
		all_cont <= 1;
		tick();
		all_cont <= 0;
		snap(n0);
		tick(100);
		snap(n1);
		chk("cont", n1 > n0, 1);
		// Point sequence: each manual trigger must bring exactly one start, noted in advance.
		trig_src <= `STS_TS_MAN;
		seq_mode <= `STS_SQ_POINT;
		num_points <= 8'h03;
		delay_cyc <= 16'h0000;
		tick(40);
		mon_on <= 1;
		for (int p = 0; p < 3; p++) begin
			tick(30);
			qs.push_back(cyc + 4);
			manual_trig <= 1;
			tick();
			manual_trig <= 0;
		end
		tick(30);
		chk("point_left", qs.size(), 0);
		// Multiple triggers: input one starts sweeps, input two steps points; the other input is ignored.
		trig_src <= `STS_TS_MULTI;
		msrc_sweep <= `STS_MS_EXT1;
		msrc_point <= `STS_MS_EXT2;
		restart <= 1;
		tick();
		restart <= 0;
		tick(20);
		ext2_in <= 1;
		tick(20);
		ext2_in <= 0;
		ext1_in <= 0;
		tick(20);
		qs.push_back(cyc + 8);
		ext1_in <= 1;
		tick(30);
		ext1_in <= 0;
		tick(20);
		ext1_in <= 1;
		tick(20);
		repeat (2) begin
			qs.push_back(cyc + 8);
			ext2_in <= 1;
			tick(30);
			ext2_in <= 0;
			tick(20);
		end
		chk("multi_left", qs.size(), 0);
		// Level mode: measures freely while the pin is high and stops once it falls.
		mon_on <= 0;
		trig_src <= `STS_TS_EXT;
		sig_type <= `STS_SL_HIGH;
		snap(n0);
		tick(100);
		snap(n1);
		chk("level_on", n1 - n0 >= 3, 1);
		ext1_in <= 0;
		tick(20);
		snap(n0);
		tick(100);
		snap(n1);
		chk("level_off", n1 - n0, 0);
		conclude();
	end
endmodule // sts_sequencer_tb
`default_nettype wire
